// ---- psr_far.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Far side: parallel and serial source pins
// ****************************************************************
module psr_far
   import psr_pkg::*;
(
   input  wire logic              i_clk_sys,      // System clock
   output logic                   o_shift_clk,    // Clock pin, idles high
   output logic                   o_clk_inhibit,  // Inhibit pin
   output logic                   o_shift_load,   // High shifts, low loads
   output logic                   o_serial,       // Serial data
   output logic [STAGES-1:0]      o_parallel      // Parallel data
);
   // Idle levels at time zero
   initial begin
      o_shift_clk   = 1'b1;
      o_clk_inhibit = 1'b0;
      o_shift_load  = 1'b1;
      o_serial      = 1'b0;
      o_parallel    = 8'h00;
   end
   // Each level holds four clocks, enough for the synchroniser
   task automatic set_pins(input logic clk, input logic inh, input logic ser);
      o_shift_clk   <= clk;
      o_clk_inhibit <= inh;
      o_serial      <= ser;
      repeat (4) @(posedge i_clk_sys);
   endtask : set_pins
   // Load pulse, then the released lines show the inverse
   task automatic load(input logic [STAGES-1:0] d);
      o_parallel   <= d;
      o_shift_load <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      o_shift_load <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_parallel   <= ~d;
      repeat (4) @(posedge i_clk_sys);
   endtask : load
   // One falling edge of the clock pin
   task automatic shift(input logic ser);
      set_pins(1'b0, 1'b0, ser);
      set_pins(1'b1, 1'b0, ser);
   endtask : shift
   // Inhibited toggles, then one shift by the inhibit pin
   task automatic gated(input logic ser);
      set_pins(1'b1, 1'b1, ser);
      set_pins(1'b0, 1'b1, ser);
      set_pins(1'b1, 1'b1, ser);
      set_pins(1'b0, 1'b1, ser);
      set_pins(1'b0, 1'b0, ser);
      set_pins(1'b1, 1'b0, ser);
   endtask : gated
endmodule : psr_far

// ---- psr_shift.sv ----
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
// Contract
// [RQ1] Enabled clock shifts eight stages toward last
// [RQ2] Eight parallel inputs act while load low
// [RQ3] Last stage given true and complemented
// [RQ4] Shift clock is NOR of clock, inhibit
// [RQ5] Either clock input high holds all stages
// [RQ6] One clock low, load high: other shifts
// [RQ7] Source raises inhibit only while clock high
// [RQ8] Parallel inputs ignored while load high
// [RQ9] Falling load loads all stages directly
// [RQ10] Rising shift clock: serial into first
// [RQ11] No rising shift clock: stages hold
module psr_shift
   import psr_pkg::*;
#(
   parameter int N_STAGES = STAGES                     // Register length
) (
   input  wire logic              i_clk_sys,           // System clock, 25 MHz
   input  wire logic              i_nrst,              // Synchronous reset, low
   input  wire logic              i_shift_clk,         // Clock pin
   input  wire logic              i_clk_inhibit,       // Clock inhibit pin
   input  wire logic              i_shift_load,        // High shifts, low loads
   input  wire logic              i_serial,            // Serial data into first stage
   input  wire logic [N_STAGES-1:0] i_parallel,        // Parallel data, bit 0 first stage
   input  wire logic [ADDR_W-1:0] i_addr,              // Register address
   input  wire logic [DATA_W-1:0] i_wr_data,           // Register write data
   input  wire logic              i_wr,                // Write strobe
   input  wire logic              i_rd,                // Read strobe
   output logic      [DATA_W-1:0] o_rd_data,           // Read data, cycle after strobe
   output logic                   o_first_stage_out,   // First stage
   output logic                   o_last_stage_out,    // Last stage, true
   output logic                   o_last_stage_out_n   // Last stage, complement
);
   // ****************************************************************
   // Parameter check
   // ****************************************************************
   // Refuse lengths the shift path and read port cannot serve
   if (N_STAGES < 2 || N_STAGES > DATA_W) begin : g_bad_stages
      $error("psr_shift: N_STAGES out of range");
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   localparam int SW = N_STAGES + 4;                   // Synchronised bit count

   logic [SW-1:0]       pins_s;                        // Synchronised pin bundle
   logic                clk_s;                         // Clock pin, synchronised
   logic                inh_s;                         // Inhibit pin, synchronised
   logic                sl_s;                          // Shift/load pin, synchronised
   logic                sl_n_s;                        // Shift/load pin inverted, synchronised
   logic                ser_s;                         // Serial pin, synchronised
   logic [N_STAGES-1:0] par_s;                         // Parallel pins, synchronised

   psr_sync #(
      .WIDTH     (SW)
   ) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_async   ({i_shift_clk, i_clk_inhibit, ~i_shift_load, i_serial, i_parallel}),
      .o_sync    (pins_s)
   );

   // Shift/load crosses inverted, so the cleared flops read as shift mode
   // and no stray load of the pins follows a reset
   assign {clk_s, inh_s, sl_n_s, ser_s, par_s} = pins_s;
   assign sl_s = ~sl_n_s;

   // ****************************************************************
   // Block state
   // ****************************************************************
   typedef struct packed {
      logic [N_STAGES-1:0] stage;                      // Stage contents
      logic                last_n;                     // Complement of last stage
      logic                eclk;                       // Previous effective clock
      logic                pause;                      // Software shift pause
      logic [CNT_W-1:0]    count;                      // Shifts since clear
      logic [DATA_W-1:0]   rd_data;                    // Read data register
   } psr_state_t;

   psr_state_t s_q;                                    // Present state
   psr_state_t s_d;                                    // Next state

   logic eclk_now;                                     // Effective clock level
   logic eclk_rise;                                    // Effective clock rising
   logic do_shift;                                     // Shift this cycle

   // [RQ4] NOR clock gate
   assign eclk_now  = ~(clk_s | inh_s);
   // [RQ6] Falling enabled input shifts
   assign eclk_rise = eclk_now & ~s_q.eclk;
   // [RQ5] Either input high blocks
   assign do_shift  = sl_s & eclk_rise & ~s_q.pause;

   // ****************************************************************
   // Next state logic
   // ****************************************************************
   always_comb begin
      s_d      = s_q;
      s_d.eclk = eclk_now;
      // [RQ2] Load while low
      if (!sl_s) begin
         // [RQ9] Direct parallel load
         s_d.stage = par_s;
      end else if (do_shift) begin
         // [RQ1] Move toward last
         // [RQ10] Serial enters first stage
         s_d.stage = {s_q.stage[N_STAGES-2:0], ser_s};
         s_d.count = s_q.count + CNT_W'(1);
      end else begin
         // [RQ8] Parallel inputs ignored
         // [RQ11] Hold without edge
         s_d.stage = s_q.stage;
      end
      // [RQ3] Complement tracks last stage
      s_d.last_n = ~s_d.stage[N_STAGES-1];
      // Register writes
      if (i_wr) begin
         case (i_addr)
            ADDR_CTRL:  s_d.pause = i_wr_data[CTRL_PAUSE];
            ADDR_COUNT: s_d.count = '0;
            default:    s_d.pause = s_q.pause;
         endcase
      end
      // Register reads, answered next cycle only
      s_d.rd_data = RD_ZERO;
      if (i_rd) begin
         case (i_addr)
            ADDR_STAGES: s_d.rd_data = DATA_W'(s_q.stage);
            ADDR_CTRL:   s_d.rd_data = DATA_W'(s_q.pause);
            ADDR_COUNT:  s_d.rd_data = DATA_W'(s_q.count);
            default:     s_d.rd_data = RD_ZERO;
         endcase
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s_q.stage   <= N_STAGES'(STAGE_RST);
         s_q.last_n  <= 1'b1;
         s_q.eclk    <= 1'b1;
         s_q.pause   <= 1'b0;
         s_q.count   <= '0;
         s_q.rd_data <= RD_ZERO;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign o_rd_data          = s_q.rd_data;
   assign o_first_stage_out  = s_q.stage[0];
   assign o_last_stage_out   = s_q.stage[N_STAGES-1];
   assign o_last_stage_out_n = s_q.last_n;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);

   a_shift_one_stage: assert property ( // [RQ1]
      sl_s && eclk_rise && !s_q.pause |=>
         s_q.stage[N_STAGES-1:1] == $past(s_q.stage[N_STAGES-2:0]))
      else $error("stages did not move one place");

   a_load_while_low: assert property ( // [RQ2]
      !sl_s |=> s_q.stage == $past(par_s))
      else $error("parallel data not taken while load low");

   a_last_pair_out: assert property ( // [RQ3]
      o_last_stage_out_n == ~o_last_stage_out && o_last_stage_out == s_q.stage[N_STAGES-1])
      else $error("last stage outputs disagree");

   a_nor_gate_clk: assert property ( // [RQ4]
      s_q.eclk == $past(~(clk_s | inh_s)))
      else $error("effective clock not the NOR of its inputs");

   a_inhibit_holds: assert property ( // [RQ5]
      sl_s && (clk_s || inh_s) |=> $stable(s_q.stage))
      else $error("stages moved while a clock input was high");

   a_other_clk_shift: assert property ( // [RQ6]
      sl_s && !inh_s && !s_q.pause && $rose(~clk_s) && !clk_s |=>
         s_q.stage[0] == $past(ser_s))
      else $error("no shift on enabled clock input");

   a_parallel_ignored: assert property ( // [RQ8]
      sl_s && !eclk_rise |=> $stable(s_q.stage))
      else $error("stages changed while load high and no edge");

   a_fall_loads: assert property ( // [RQ9]
      $fell(sl_s) ##1 1 |-> s_q.stage == $past(par_s))
      else $error("falling load did not load");

   a_serial_entry: assert property ( // [RQ10]
      do_shift |=> s_q.stage[0] == $past(ser_s) &&
         s_q.count == ($past(i_wr && i_addr == ADDR_COUNT) ? '0 : $past(s_q.count) + CNT_W'(1)))
      else $error("serial bit did not enter first stage");

   a_hold_no_edge: assert property ( // [RQ11]
      sl_s && !inh_s && !clk_s && !eclk_rise |=> s_q.stage == $past(s_q.stage))
      else $error("stages changed with clock held low");

   // Output pins follow the stages after a shift or a load
   a_last_takes_prev: assert property ( // [RQ3]
      do_shift |=> o_last_stage_out == $past(s_q.stage[N_STAGES-2]) &&
         o_last_stage_out_n != $past(s_q.stage[N_STAGES-2]))
      else $error("last stage outputs missed the shift");

   a_load_drives_outs: assert property ( // [RQ2]
      !sl_s |=> o_first_stage_out == $past(par_s[0]) &&
         o_last_stage_out == $past(par_s[N_STAGES-1]))
      else $error("loaded data not on the stage outputs");

   // Software pause holds the stages in shift mode; counter moves only with real shifts or a clear
   a_pause_holds: assert property ( // [RQ11]
      sl_s && s_q.pause |=> $stable(s_q.stage))
      else $error("stages moved while shifting paused");

   a_count_only_shift: assert property ( // [RQ10]
      !do_shift && !(i_wr && i_addr == ADDR_COUNT) |=> $stable(s_q.count))
      else $error("shift counter moved without a shift");
endmodule : psr_shift

// ---- psr_sync.sv ----
`timescale 1ns/10ps
// ****************************************************************
// Shared constants
// ****************************************************************
package psr_pkg;
   localparam int          STAGES       = 8;          // Register length
   localparam int          SYNC_DEPTH   = 2;          // Flops per pin synchroniser
   localparam int          ADDR_W       = 4;          // Register port address width
   localparam int          DATA_W       = 16;         // Register port data width
   localparam int          CNT_W        = 16;         // Shift counter width
   localparam logic [3:0]  ADDR_STAGES  = 4'h0;       // Stage contents, read only
   localparam logic [3:0]  ADDR_CTRL    = 4'h1;       // Control, bit 0 pauses shifting
   localparam logic [3:0]  ADDR_COUNT   = 4'h2;       // Shift counter, write clears
   localparam int          CTRL_PAUSE   = 0;          // Pause bit position
   localparam logic [7:0]  STAGE_RST    = 8'h00;      // Stage reset value
   localparam logic [15:0] RD_ZERO      = 16'h0000;   // Unmapped read answer
endpackage : psr_pkg

// ****************************************************************
// Two-flop pin synchroniser, state in one packed struct
// ****************************************************************
module psr_sync #(
   parameter int WIDTH = 12                            // Bits synchronised
) (
   input  wire logic             i_clk_sys,            // System clock
   input  wire logic             i_nrst,               // Synchronous reset, low
   input  wire logic [WIDTH-1:0] i_async,              // Pin levels
   output logic      [WIDTH-1:0] o_sync                // Synchronised levels
);
   // Capture and settle flops
   typedef struct packed {
      logic [WIDTH-1:0] meta;                          // First flop, read only by second
      logic [WIDTH-1:0] safe;                          // Second flop
   } psr_sync_t;

   psr_sync_t s_q;                                     // Present state
   psr_sync_t s_d;                                     // Next state

   // Refuse an empty synchroniser at elaboration
   if (WIDTH < 1) begin : g_bad_width
      $error("psr_sync: WIDTH must be at least 1");
   end

   // Next state: shift pins through the two flops
   always_comb begin
      s_d      = s_q;
      s_d.meta = i_async;
      s_d.safe = s_q.meta;
   end

   // State register with synchronous reset
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_sync = s_q.safe;
endmodule : psr_sync

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top
   import psr_pkg::*;
;
   logic              clk_sys = 1'b0;   // System clock
   logic              nrst    = 1'b0;   // Reset, low
   logic [3:0]        addr    = 4'h0;   // Register address
   logic [15:0]       wdata   = 16'h0000;
   logic              wr      = 1'b0;   // Write strobe
   logic              rd      = 1'b0;   // Read strobe
   logic              rd_q    = 1'b0;   // Read taken last edge
   wire               sclk, inh, sload, ser;
   wire  [7:0]        par;
   wire  [15:0]       rd_data;
   wire               first, last, last_n;
   logic [18:0]       notes[$];         // Expected read results
   logic [18:0]       note, got;
   logic [7:0]        exp, d;           // Stage model
   logic [15:0]       cnt;              // Shift count model
   logic              s;
   integer            seed = 32'hE542;
   int                bad_count = 0, check_count = 0, cyc = 0;
   always #20 clk_sys = ~clk_sys;
   psr_far far_u (.i_clk_sys(clk_sys), .o_shift_clk(sclk), .o_clk_inhibit(inh),
      .o_shift_load(sload), .o_serial(ser), .o_parallel(par));
   psr_shift dut_u (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_shift_clk(sclk),
      .i_clk_inhibit(inh), .i_shift_load(sload), .i_serial(ser), .i_parallel(par),
      .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data),
      .o_first_stage_out(first), .o_last_stage_out(last), .o_last_stage_out_n(last_n));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk_sys);
      addr <= a; wdata <= v; wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg
   // Read and note the read data with the three stage outputs
   task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk_sys);
      addr <= a; rd <= 1'b1;
      notes.push_back({e, exp[0], exp[7], ~exp[7]});
      @(posedge clk_sys);
      rd <= 1'b0;
   endtask : rd_reg
   // Compare each answer, one cycle after its strobe
   always @(posedge clk_sys) begin
      rd_q <= rd;
      cyc  <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
      if (rd_q) begin
         got  = {rd_data, first, last, last_n};
         note = notes.pop_front();
         check_count++;
         if (got !== note) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, note);
         end
      end
   end
   initial begin
      exp = STAGE_RST;
      cnt = 16'h0000;
      repeat (12) @(posedge clk_sys);
      nrst <= 1'b1;
      rd_reg(ADDR_STAGES, 16'h0000);
      rd_reg(ADDR_COUNT, 16'h0000);
      d = 8'($random(seed));
      far_u.load(d);
      exp = d;
      rd_reg(ADDR_STAGES, {8'h00, exp});
      for (int i = 0; i < STAGES; i++) begin
         s = 1'($random(seed));
         far_u.shift(s);
         exp = {exp[6:0], s};
         cnt++;
         rd_reg(ADDR_STAGES, {8'h00, exp});
      end
      far_u.gated(1'b1);
      exp = {exp[6:0], 1'b1};
      cnt++;
      rd_reg(ADDR_STAGES, {8'h00, exp});
      rd_reg(ADDR_COUNT, cnt);
      wr_reg(ADDR_CTRL, 16'h0001);
      rd_reg(ADDR_CTRL, 16'h0001);
      far_u.shift(1'b0);
      rd_reg(ADDR_STAGES, {8'h00, exp});
      wr_reg(ADDR_CTRL, 16'h0000);
      wr_reg(ADDR_COUNT, 16'hFFFF);
      rd_reg(ADDR_COUNT, 16'h0000);
      wr_reg(ADDR_STAGES, 16'h00A5);
      rd_reg(ADDR_STAGES, {8'h00, exp});
      rd_reg(4'hF, 16'h0000);
      far_u.set_pins(1'b0, 1'b0, 1'b1);
      d = 8'($random(seed));
      far_u.load(d);
      exp = d;
      rd_reg(ADDR_STAGES, {8'h00, exp});
      far_u.set_pins(1'b1, 1'b0, 1'b1);
      rd_reg(ADDR_STAGES, {8'h00, exp});
      // Mid-run reset with pause set: all state must clear
      wr_reg(ADDR_CTRL, 16'h0001);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      exp = STAGE_RST;
      cnt = 16'h0000;
      rd_reg(ADDR_STAGES, {8'h00, exp});
      rd_reg(ADDR_CTRL, 16'h0000);
      s = 1'($random(seed));
      far_u.shift(s);
      exp = {exp[6:0], s};
      cnt++;
      rd_reg(ADDR_STAGES, {8'h00, exp});
      rd_reg(ADDR_COUNT, cnt);
      repeat (3) @(posedge clk_sys);
      give_verdict();
   end
endmodule : tb_top
